// File: panel_monitor_pkg.sv
// constants and types shared by the front-panel monitor block
package panel_monitor_pkg;
  // power-on display selection register
  localparam logic [15:0] SEL_REG_OFFSET = 16'h2528; // register index/address
  localparam logic [15:0] SEL_RESET = 16'h0022; // servo status view
  localparam logic [5:0] SEL_MAX = 6'h2A; // highest legal selection
  // monitor item codes used by this block
  localparam logic [5:0] ITEM_IO = 6'h0A;
  localparam logic [5:0] ITEM_ANALOG = 6'h0B;
  localparam logic [5:0] ITEM_INERTIA = 6'h10;
  localparam logic [5:0] ITEM_CAUSE = 6'h11;
  localparam logic [5:0] ITEM_SINGLE = 6'h15;
  localparam logic [5:0] ITEM_MULTI = 6'h16;
  localparam logic [5:0] ITEM_DEVIATION = 6'h18;
  localparam logic [5:0] ITEM_ENC_ERR = 6'h1E;
  localparam logic [5:0] ITEM_OP_TIME = 6'h1F;
  localparam logic [5:0] ITEM_TEMP = 6'h21;
  localparam logic [5:0] ITEM_STATUS = 6'h22;
  localparam logic [5:0] ITEM_SYNC_FIRST = 6'h24;
  localparam logic [5:0] ITEM_SYNC_LAST = 6'h27;
  localparam logic [5:0] ITEM_OD_INDEX = 6'h29;
  localparam logic [5:0] ITEM_OD_VALUE = 6'h2A;
  // encoder
  localparam int ENC_BITS = 23;
  localparam logic [22:0] SINGLE_MAX = 23'h7FFFFF; // 8388607
  localparam logic [22:0] SINGLE_RESET = 23'h000000;
  localparam logic [15:0] MULTI_RESET = 16'h0000;
  // not-running cause codes
  localparam logic [3:0] CAUSE_NORMAL = 4'h0;
  localparam logic [3:0] CAUSE_UNDERVOLT = 4'h1;
  localparam logic [3:0] CAUSE_NO_SERVO_ON = 4'h2;
  localparam logic [3:0] CAUSE_LIMIT = 4'h3;
  localparam logic [3:0] CAUSE_ALARM = 4'h4;
  localparam logic [3:0] CAUSE_RELAY = 4'h5;
  localparam logic [3:0] CAUSE_INHIBIT = 4'h6;
  localparam logic [3:0] CAUSE_CMD_LOW = 4'h7;
  localparam logic [3:0] CAUSE_CLEAR = 4'h8;
  localparam logic [3:0] CAUSE_CLAMP = 4'h9;
  localparam logic [1:0] CLAMP_MODE_ON = 2'h1;
  // seven-segment bits: {dp,g,f,e,d,c,b,a}
  localparam logic [7:0] SEG_TOP = 8'h01; // a
  localparam logic [7:0] SEG_MID = 8'h40; // g
  localparam logic [7:0] SEG_BOT = 8'h08; // d
  localparam logic [7:0] SEG_UPPER_PAIR = 8'h22; // f,b
  localparam logic [7:0] SEG_LOWER_PAIR = 8'h14; // e,c
  localparam logic [7:0] SEG_DP = 8'h80;
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_LETTER_A = 8'h77;
  localparam logic [7:0] SEG_LETTER_F = 8'h71;
  localparam logic [7:0] SEG_LETTER_H = 8'h76;
  // deviation sources
  typedef enum logic [1:0] {
    DEV_MOTOR = 2'b00,
    DEV_FULL_CMD = 2'b01,
    DEV_FULL_ENC = 2'b10
  } dev_src_e;
endpackage

// File: seg_digit.sv
// hex nibble to seven-segment pattern with decimal point
`timescale 1ns/10ps
`default_nettype none
module seg_digit (
  input wire logic [3:0] nibble,
  input wire logic dp,
  output logic [7:0] seg
);
  // pattern lookup, bit 7 is the decimal point
  always_comb begin
    unique case (nibble)
      4'h0: seg[6:0] = 7'h3F;
      4'h1: seg[6:0] = 7'h06;
      4'h2: seg[6:0] = 7'h5B;
      4'h3: seg[6:0] = 7'h4F;
      4'h4: seg[6:0] = 7'h66;
      4'h5: seg[6:0] = 7'h6D;
      4'h6: seg[6:0] = 7'h7D;
      4'h7: seg[6:0] = 7'h07;
      4'h8: seg[6:0] = 7'h7F;
      4'h9: seg[6:0] = 7'h6F;
      4'hA: seg[6:0] = 7'h77;
      4'hB: seg[6:0] = 7'h7C;
      4'hC: seg[6:0] = 7'h39;
      4'hD: seg[6:0] = 7'h5E;
      4'hE: seg[6:0] = 7'h79;
      4'hF: seg[6:0] = 7'h71;
    endcase
    seg[7] = dp;
  end
endmodule
`default_nettype wire

// File: panel_monitor.sv
// front-panel monitor: formats drive quantities for a five-digit display
// What this block does
// - active signal lights upper pair, else lower
// - inputs right-to-left, decimal point lit
// - outputs right-to-left, decimal point dark
// - analog bars top/middle/bottom, points mark negative
// - single-turn position spans 0 to 8388607
// - ccw wrap increments turns, cw wrap decrements
// - turn count signed 16-bit, wraps both ways
// - up/down keys pick three tagged deviation sources
// - cause code 0 to 9 shown
// - limit and clamp causes from their conditions
// - left key toggles operating time halves
// - status view combines four status fields
// - holding mode key copies measured inertia ratio
// - selection 0 to 42, reset 34, reset reloads 34 before the restart takes it
// - selection values map to monitor items
`timescale 1ns/10ps
`default_nettype none
module panel_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port for the power-on display selection
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // operator keys, one-cycle pulses except mode hold level
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_left,
  input wire logic key_mode_hold,
  input wire logic [5:0] key_view_sel,
  input wire logic key_view_load,
  // drive status sources
  input wire logic [9:0] di_active,
  input wire logic [9:0] do_active,
  input wire logic [2:0] analog_level,
  input wire logic [2:0] analog_negative,
  input wire logic enc_step,
  input wire logic enc_ccw,
  input wire logic [15:0] dev_motor,
  input wire logic [15:0] dev_full_cmd,
  input wire logic [15:0] dev_full_enc,
  input wire logic bus_undervolt,
  input wire logic servo_on_input,
  input wire logic limit_function_setting,
  input wire logic positive_limit_input,
  input wire logic negative_limit_input,
  input wire logic vel_cmd_positive,
  input wire logic vel_cmd_negative,
  input wire logic drive_alarm,
  input wire logic relay_closed,
  input wire logic pulse_inhibit_setting,
  input wire logic pulse_inhibit_input,
  input wire logic cmd_too_small,
  input wire logic counter_clear_setting,
  input wire logic counter_clear_input,
  input wire logic [1:0] zero_speed_clamp_mode,
  input wire logic zero_speed_clamp_input,
  input wire logic [31:0] operating_time,
  input wire logic [3:0] drive_state,
  input wire logic [3:0] comm_state,
  input wire logic [3:0] run_mode,
  input wire logic [3:0] run_condition,
  input wire logic [15:0] measured_inertia,
  input wire logic [15:0] generic_value,
  // panel and parameter outputs
  output logic [39:0] seg_out,
  output logic [5:0] shown_item,
  output logic [3:0] cause_code,
  output logic [22:0] single_turn,
  output logic [15:0] multiturn,
  output logic [15:0] inertia_ratio_param,
  output logic inertia_write
);
  // all block state
  typedef struct packed {
    logic [15:0] sel; // stored selection, reloaded with SEL_RESET at restart
    logic started; // selection already sampled after reset
    logic [5:0] item; // item on the panel
    logic [1:0] dev_src; // deviation source
    logic time_high; // operating time half shown
    logic [22:0] single; // single-turn position
    logic [15:0] multi; // turn count
    logic [3:0] cause; // not-running cause
    logic [15:0] inertia; // inertia ratio parameter
    logic hold_done; // mode hold already served
    logic wr_pulse; // inertia write strobe
    logic [39:0] seg; // display latch
  } state_s;
  state_s cur, nxt;
  logic [39:0] raw_seg; // digits from the formatter
  logic [19:0] digit_val; // hex value for five digits
  logic [4:0] digit_dp; // decimal points from value views
  logic [39:0] hex_seg; // decoded value digits
  logic [3:0] cause_now; // combinational cause
  logic [15:0] dev_sel; // selected deviation
  logic [7:0] dev_tag; // prefix letter
  // five hex digit decoders
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_dig
      seg_digit u_dig (
        .nibble(digit_val[gi*4 +: 4]),
        .dp(digit_dp[gi]),
        .seg(hex_seg[gi*8 +: 8])
      );
    end
  endgenerate
  // not-running cause, lowest code with a true condition wins
  always_comb begin
    cause_now = panel_monitor_pkg::CAUSE_NORMAL;
    if (bus_undervolt) begin
      cause_now = panel_monitor_pkg::CAUSE_UNDERVOLT;
    end else if (!servo_on_input) begin
      cause_now = panel_monitor_pkg::CAUSE_NO_SERVO_ON;
    end else if (limit_function_setting &&
        ((!positive_limit_input && vel_cmd_positive) ||
         (!negative_limit_input && vel_cmd_negative))) begin
      cause_now = panel_monitor_pkg::CAUSE_LIMIT;
    end else if (drive_alarm) begin
      cause_now = panel_monitor_pkg::CAUSE_ALARM;
    end else if (!relay_closed) begin
      cause_now = panel_monitor_pkg::CAUSE_RELAY;
    end else if (pulse_inhibit_setting && pulse_inhibit_input) begin
      cause_now = panel_monitor_pkg::CAUSE_INHIBIT;
    end else if (cmd_too_small) begin
      cause_now = panel_monitor_pkg::CAUSE_CMD_LOW;
    end else if (counter_clear_setting && counter_clear_input) begin
      cause_now = panel_monitor_pkg::CAUSE_CLEAR;
    end else if (zero_speed_clamp_mode == panel_monitor_pkg::CLAMP_MODE_ON &&
        !zero_speed_clamp_input) begin
      cause_now = panel_monitor_pkg::CAUSE_CLAMP;
    end
  end
  // deviation source mux and its tag letter
  always_comb begin
    unique case (panel_monitor_pkg::dev_src_e'(cur.dev_src))
      panel_monitor_pkg::DEV_FULL_CMD: begin
        dev_sel = dev_full_cmd;
        dev_tag = panel_monitor_pkg::SEG_LETTER_F;
      end
      panel_monitor_pkg::DEV_FULL_ENC: begin
        dev_sel = dev_full_enc;
        dev_tag = panel_monitor_pkg::SEG_LETTER_H;
      end
      default: begin
        dev_sel = dev_motor;
        dev_tag = panel_monitor_pkg::SEG_LETTER_A;
      end
    endcase
  end
  // per-item digit formatting
  always_comb begin
    digit_val = 20'h00000;
    digit_dp = 5'b00000;
    raw_seg = hex_seg;
    unique case (cur.item)
      panel_monitor_pkg::ITEM_IO: begin
        // digits 0..4 inputs DI1..DI10, two per digit: even bit right, odd bit left
        for (int k = 0; k < 5; k++) begin
          raw_seg[k*8 +: 8] =
            (di_active[2*k] ? 8'h02 : 8'h04) |
            (di_active[2*k+1] ? 8'h20 : 8'h10) |
            panel_monitor_pkg::SEG_DP;
        end
        if (cur.time_high) begin
          // left key flips to outputs, points dark
          for (int k = 0; k < 5; k++) begin
            raw_seg[k*8 +: 8] =
              (do_active[2*k] ? 8'h02 : 8'h04) |
              (do_active[2*k+1] ? 8'h20 : 8'h10);
          end
        end
      end
      panel_monitor_pkg::ITEM_ANALOG: begin
        raw_seg = {40{1'b0}};
        raw_seg[39:32] =
          (analog_level[0] ? panel_monitor_pkg::SEG_TOP : 8'h00) |
          (analog_level[1] ? panel_monitor_pkg::SEG_MID : 8'h00) |
          (analog_level[2] ? panel_monitor_pkg::SEG_BOT : 8'h00);
        // sign points sit on the two leftmost digits
        if (|analog_negative) begin
          raw_seg[39] = 1'b1;
          raw_seg[31] = 1'b1;
        end
      end
      panel_monitor_pkg::ITEM_SINGLE: begin
        digit_val = cur.time_high ? {17'h00000, cur.single[22:20]}
                                  : cur.single[19:0];
        digit_dp = cur.time_high ? 5'b00011 : 5'b00000;
        raw_seg = hex_seg;
      end
      panel_monitor_pkg::ITEM_MULTI: begin
        digit_val = {4'h0, cur.multi};
        raw_seg = hex_seg;
      end
      panel_monitor_pkg::ITEM_DEVIATION: begin
        digit_val = {4'h0, dev_sel};
        raw_seg = {dev_tag, hex_seg[31:0]};
      end
      panel_monitor_pkg::ITEM_CAUSE: begin
        digit_val = {16'h0000, cur.cause};
        raw_seg = hex_seg;
      end
      panel_monitor_pkg::ITEM_OP_TIME: begin
        digit_val = cur.time_high ? {4'h0, operating_time[31:16]}
                                  : {4'h0, operating_time[15:0]};
        digit_dp = cur.time_high ? 5'b00011 : 5'b00000;
        raw_seg = hex_seg;
      end
      panel_monitor_pkg::ITEM_STATUS: begin
        digit_val = {4'h0, drive_state, comm_state, run_mode, run_condition};
        raw_seg = hex_seg;
      end
      panel_monitor_pkg::ITEM_INERTIA: begin
        digit_val = {4'h0, measured_inertia};
        raw_seg = hex_seg;
      end
      default: begin
        // other items show their generic value
        digit_val = {4'h0, generic_value};
        raw_seg = hex_seg;
      end
    endcase
  end
  // next-state logic
  always_comb begin
    nxt = cur;
    nxt.wr_pulse = 1'b0;
    nxt.cause = cause_now;
    nxt.seg = raw_seg;
    // selection register write, out-of-range values ignored
    if (reg_wr && reg_addr == panel_monitor_pkg::SEL_REG_OFFSET &&
        reg_wdata <= {10'h000, panel_monitor_pkg::SEL_MAX}) begin
      nxt.sel = reg_wdata;
    end
    // first cycle after reset release: take the stored selection
    if (!cur.started) begin
      nxt.started = 1'b1;
      nxt.item = cur.sel[5:0];
    end else if (key_view_load && key_view_sel <= panel_monitor_pkg::SEL_MAX) begin
      nxt.item = key_view_sel;
      nxt.time_high = 1'b0;
    end
    // deviation source stepping
    if (cur.item == panel_monitor_pkg::ITEM_DEVIATION) begin
      if (key_up) begin
        nxt.dev_src = (cur.dev_src == 2'b10) ? 2'b00 : cur.dev_src + 2'b01;
      end else if (key_down) begin
        nxt.dev_src = (cur.dev_src == 2'b00) ? 2'b10 : cur.dev_src - 2'b01;
      end
    end
    // left key toggles halves
    if (key_left && cur.started && !key_view_load) begin
      nxt.time_high = !cur.time_high;
    end
    // encoder position tracking with wrap
    if (enc_step) begin
      if (enc_ccw) begin
        if (cur.single == panel_monitor_pkg::SINGLE_MAX) begin
          nxt.single = 23'h000000;
          nxt.multi = cur.multi + 16'h0001;
        end else begin
          nxt.single = cur.single + 23'h000001;
        end
      end else begin
        if (cur.single == 23'h000000) begin
          nxt.single = panel_monitor_pkg::SINGLE_MAX;
          nxt.multi = cur.multi - 16'h0001;
        end else begin
          nxt.single = cur.single - 23'h000001;
        end
      end
    end
    // inertia write once per mode-key hold
    if (key_mode_hold && cur.item == panel_monitor_pkg::ITEM_INERTIA) begin
      if (!cur.hold_done) begin
        nxt.inertia = measured_inertia;
        nxt.wr_pulse = 1'b1;
        nxt.hold_done = 1'b1;
      end
    end else begin
      nxt.hold_done = 1'b0;
    end
  end
  // state register; selection register survives only as reset value
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cur <= '0;
      cur.sel <= panel_monitor_pkg::SEL_RESET;
      cur.item <= panel_monitor_pkg::ITEM_STATUS;
      cur.single <= panel_monitor_pkg::SINGLE_RESET;
      cur.multi <= panel_monitor_pkg::MULTI_RESET;
    end else begin
      cur <= nxt;
    end
  end
  // outputs
  assign reg_rdata = cur.sel;
  assign seg_out = cur.seg;
  assign shown_item = cur.item;
  assign cause_code = cur.cause;
  assign single_turn = cur.single;
  assign multiturn = cur.multi;
  assign inertia_ratio_param = cur.inertia;
  assign inertia_write = cur.wr_pulse;
endmodule
`default_nettype wire

// File: panel_monitor_properties.sv
// port assertions for the front-panel monitor
`timescale 1ns/10ps
`default_nettype none
module panel_monitor_properties (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic enc_step,
  input wire logic enc_ccw,
  input wire logic bus_undervolt,
  input wire logic servo_on_input,
  input wire logic limit_function_setting,
  input wire logic positive_limit_input,
  input wire logic vel_cmd_positive,
  input wire logic key_mode_hold,
  input wire logic [5:0] shown_item,
  input wire logic [3:0] cause_code,
  input wire logic [22:0] single_turn,
  input wire logic [15:0] multiturn,
  input wire logic inertia_write
);
  // one clock domain, reset disables all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // selection holds its default at release
  property p_sel_reset;
    $rose(rst_b) |-> reg_rdata == panel_monitor_pkg::SEL_RESET;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("selection not default");
  // item taken from selection once
  property p_item_load;
    $rose(rst_b) |=> shown_item == $past(reg_rdata[5:0]);
  endproperty
  a_item_load: assert property (p_item_load) else $error("item not sampled");
  // legal write lands next cycle
  property p_sel_write;
    reg_wr && reg_addr == panel_monitor_pkg::SEL_REG_OFFSET && reg_wdata <= 16'h002A
      |=> reg_rdata == $past(reg_wdata);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selection write lost");
  // each step moves position by one, both ways
  property p_step;
    enc_step |=> single_turn == $past(single_turn) + ($past(enc_ccw) ? 23'h000001 : 23'h7FFFFF);
  endproperty
  a_step: assert property (p_step) else $error("position step wrong");
  // ccw wrap counts a turn up
  property p_turn_up;
    enc_step && enc_ccw && single_turn == panel_monitor_pkg::SINGLE_MAX
      |=> multiturn == $past(multiturn) + 16'h0001;
  endproperty
  a_turn_up: assert property (p_turn_up) else $error("turn count up wrong");
  // cw wrap counts a turn down
  property p_turn_down;
    enc_step && !enc_ccw && single_turn == 23'h000000 |=> multiturn == $past(multiturn) - 16'h0001;
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("turn count down wrong");
  // open positive limit under a positive command
  property p_limit;
    !bus_undervolt && servo_on_input && limit_function_setting && !positive_limit_input
      && vel_cmd_positive |=> cause_code == panel_monitor_pkg::CAUSE_LIMIT;
  endproperty
  a_limit: assert property (p_limit) else $error("limit cause missing");
  // mode hold on inertia view writes soon
  property p_inertia;
    $rose(key_mode_hold) && shown_item == panel_monitor_pkg::ITEM_INERTIA |-> ##[1:2] inertia_write;
  endproperty
  a_inertia: assert property (p_inertia) else $error("inertia not written");
  // write strobe lasts one cycle
  property p_write_pulse;
    inertia_write |=> !inertia_write;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("inertia strobe too long");
endmodule
bind panel_monitor panel_monitor_properties u_props (.clk_sys, .rst_b, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata, .enc_step, .enc_ccw, .bus_undervolt, .servo_on_input,
  .limit_function_setting, .positive_limit_input, .vel_cmd_positive, .key_mode_hold,
  .shown_item, .cause_code, .single_turn, .multiturn, .inertia_write);
`default_nettype wire

// File: panel_keys.sv
// operator key pad model of the led panel
`timescale 1ns/10ps
`default_nettype none
module panel_keys (
  input wire logic clk_sys,
  output logic key_up,
  output logic key_down,
  output logic key_left,
  output logic key_mode_hold,
  output logic [5:0] key_view_sel,
  output logic key_view_load
);
  // all keys idle at start
  initial begin
    {key_up, key_down, key_left, key_mode_hold, key_view_load} = 5'h00;
    key_view_sel = 6'h00;
  end
  // one-cycle pulse: 0 up, 1 down, 2 left
  task automatic press(input int k);
    @(posedge clk_sys);
    key_up <= (k == 0);
    key_down <= (k == 1);
    key_left <= (k == 2);
    @(posedge clk_sys);
    {key_up, key_down, key_left} <= 3'h0;
  endtask
  // load a view, selector scrambled after
  task automatic view(input logic [5:0] v);
    @(posedge clk_sys);
    key_view_sel <= v;
    key_view_load <= 1'b1;
    @(posedge clk_sys);
    key_view_load <= 1'b0;
    key_view_sel <= ~v;
  endtask
  // mode key level
  task automatic mode(input logic m);
    @(posedge clk_sys);
    key_mode_hold <= m;
  endtask
endmodule
`default_nettype wire

// File: front_panel_monitor_display_bench.sv
// self-checking bench for the front-panel monitor
`timescale 1ns/10ps
`default_nettype none
module front_panel_monitor_display_bench;
  // clock, reset and register port
  logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  // keys come from the panel model
  logic key_up, key_down, key_left, key_mode_hold, key_view_load;
  logic [5:0] key_view_sel;
  // status sources, idle means no stop cause
  logic [9:0] di_active = 10'h000, do_active = 10'h000;
  logic [2:0] analog_level = 3'h0, analog_negative = 3'h0;
  logic enc_step = 1'b0, enc_ccw = 1'b0, bus_undervolt = 1'b0, servo_on_input = 1'b1;
  logic [15:0] dev_motor = 16'h0000, dev_full_cmd = 16'h0000, dev_full_enc = 16'h0000;
  logic limit_function_setting = 1'b0, positive_limit_input = 1'b1, negative_limit_input = 1'b1;
  logic vel_cmd_positive = 1'b0, vel_cmd_negative = 1'b0, drive_alarm = 1'b0, relay_closed = 1'b1;
  logic pulse_inhibit_setting = 1'b0, pulse_inhibit_input = 1'b0, cmd_too_small = 1'b0;
  logic counter_clear_setting = 1'b0, counter_clear_input = 1'b0, zero_speed_clamp_input = 1'b1;
  logic [1:0] zero_speed_clamp_mode = 2'h0;
  logic [31:0] operating_time = 32'h0000_0000;
  logic [3:0] drive_state = 4'h0, comm_state = 4'h0, run_mode = 4'h0, run_condition = 4'h0;
  logic [15:0] measured_inertia = 16'h0000, generic_value = 16'h0000;
  // design outputs
  logic [39:0] seg_out;
  logic [5:0] shown_item;
  logic [3:0] cause_code;
  logic [22:0] single_turn;
  logic [15:0] multiturn, inertia_ratio_param;
  logic inertia_write;
  int bad_count = 0, compares = 0;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
  panel_monitor dut (.*);
  panel_keys keys (.*);
  // free-running system clock
  always #2.5 clk_sys = ~clk_sys;
  // let key and view effects reach the segments
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // one register write, lines scrambled after
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    settle();
  endtask
  // one encoder count, ccw when c is set
  task automatic step(input logic c);
    @(posedge clk_sys);
    enc_step <= 1'b1;
    enc_ccw <= c;
    @(posedge clk_sys);
    enc_step <= 1'b0;
    enc_ccw <= ~c;
    settle();
  endtask
  // defaults after release, then legal and refused writes
  task automatic t_reg;
    settle();
    `CHK("sel", panel_monitor_pkg::SEL_RESET, reg_rdata)
    `CHK("item", panel_monitor_pkg::ITEM_STATUS, shown_item)
    wr(16'h2528, 16'h001E);
    `CHK("sel", 16'h001E, reg_rdata)
    `CHK("item", panel_monitor_pkg::ITEM_STATUS, shown_item)
    wr(16'h2528, 16'h002B);
    wr(16'h2529, 16'h0005);
    `CHK("sel", 16'h001E, reg_rdata)
  endtask
  // wrap below zero and back
  task automatic t_enc;
    step(1'b0);
    `CHK("single", 23'h7FFFFF, single_turn)
    `CHK("multi", 16'hFFFF, multiturn)
    keys.view(panel_monitor_pkg::ITEM_SINGLE);
    settle();
    `CHK("single digits", 40'h7171717171, seg_out)
    keys.view(panel_monitor_pkg::ITEM_MULTI);
    settle();
    `CHK("multi digits", 40'h3F71717171, seg_out)
    step(1'b1);
    `CHK("single", 23'h000000, single_turn)
    `CHK("multi", 16'h0000, multiturn)
  endtask
  // input then output pages of the io view
  task automatic t_io;
    @(posedge clk_sys);
    di_active <= 10'h001;
    do_active <= 10'h200;
    keys.view(panel_monitor_pkg::ITEM_IO);
    settle();
    `CHK("item", panel_monitor_pkg::ITEM_IO, shown_item)
    `CHK("inputs", 40'h9494949492, seg_out)
    keys.press(2);
    settle();
    `CHK("outputs", 40'h2414141414, seg_out)
  endtask
  // bars and sign points
  task automatic t_analog;
    @(posedge clk_sys);
    analog_level <= 3'h5;
    analog_negative <= 3'h4;
    keys.view(panel_monitor_pkg::ITEM_ANALOG);
    settle();
    `CHK("bars", 8'h89, seg_out[39:32])
    `CHK("sign", 1'b1, seg_out[31])
  endtask
  // deviation source cycling
  task automatic t_dev;
    @(posedge clk_sys);
    dev_motor <= 16'h0011;
    dev_full_cmd <= 16'h0022;
    dev_full_enc <= 16'h0033;
    keys.view(panel_monitor_pkg::ITEM_DEVIATION);
    settle();
    `CHK("tag", panel_monitor_pkg::SEG_LETTER_A, seg_out[39:32])
    keys.press(0);
    settle();
    `CHK("tag", panel_monitor_pkg::SEG_LETTER_F, seg_out[39:32])
    `CHK("dev digits", 32'h3F3F5B5B, seg_out[31:0])
    keys.press(0);
    settle();
    `CHK("tag", panel_monitor_pkg::SEG_LETTER_H, seg_out[39:32])
    keys.press(1);
    settle();
    `CHK("tag", panel_monitor_pkg::SEG_LETTER_F, seg_out[39:32])
  endtask
  // stop causes: each new cause outranks the ones already standing
  task automatic t_cause;
    `CHK("cause", panel_monitor_pkg::CAUSE_NORMAL, cause_code)
    @(posedge clk_sys);
    bus_undervolt <= 1'b1;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_UNDERVOLT, cause_code)
    @(posedge clk_sys);
    bus_undervolt <= 1'b0;
    limit_function_setting <= 1'b1;
    positive_limit_input <= 1'b0;
    vel_cmd_positive <= 1'b1;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_LIMIT, cause_code)
    @(posedge clk_sys);
    positive_limit_input <= 1'b1;
    zero_speed_clamp_mode <= panel_monitor_pkg::CLAMP_MODE_ON;
    zero_speed_clamp_input <= 1'b0;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_CLAMP, cause_code)
    @(posedge clk_sys);
    {counter_clear_setting, counter_clear_input} <= 2'h3;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_CLEAR, cause_code)
    @(posedge clk_sys);
    cmd_too_small <= 1'b1;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_CMD_LOW, cause_code)
    @(posedge clk_sys);
    {pulse_inhibit_setting, pulse_inhibit_input} <= 2'h3;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_INHIBIT, cause_code)
    @(posedge clk_sys);
    relay_closed <= 1'b0;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_RELAY, cause_code)
    @(posedge clk_sys);
    drive_alarm <= 1'b1;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_ALARM, cause_code)
    // negative limit open against a negative command
    @(posedge clk_sys);
    vel_cmd_negative <= 1'b1;
    negative_limit_input <= 1'b0;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_LIMIT, cause_code)
    @(posedge clk_sys);
    servo_on_input <= 1'b0;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_NO_SERVO_ON, cause_code)
    keys.view(panel_monitor_pkg::ITEM_CAUSE);
    settle();
    `CHK("cause digit", 8'h5B, seg_out[7:0])
    // all stop causes back to idle
    @(posedge clk_sys);
    {servo_on_input, relay_closed, negative_limit_input} <= 3'h7;
    {drive_alarm, vel_cmd_negative, vel_cmd_positive, cmd_too_small} <= 4'h0;
    {limit_function_setting, pulse_inhibit_setting, pulse_inhibit_input} <= 3'h0;
    {counter_clear_setting, counter_clear_input} <= 2'h0;
    zero_speed_clamp_mode <= 2'h0;
    zero_speed_clamp_input <= 1'b1;
    settle();
    `CHK("cause", panel_monitor_pkg::CAUSE_NORMAL, cause_code)
  endtask
  // inertia copy, time halves, status digits
  task automatic t_views;
    int n;
    @(posedge clk_sys);
    measured_inertia <= 16'h1234;
    operating_time <= 32'h0002_1256;
    {drive_state, comm_state, run_mode, run_condition} <= 16'h1234;
    keys.view(panel_monitor_pkg::ITEM_INERTIA);
    settle();
    keys.mode(1'b1);
    // look after each edge has settled
    for (n = 0; n < 8 && inertia_write !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK("write", 1'b1, inertia_write)
    if (inertia_write !== 1'b1) complete_run();
    keys.mode(1'b0);
    settle();
    `CHK("ratio", 16'h1234, inertia_ratio_param)
    keys.view(panel_monitor_pkg::ITEM_OP_TIME);
    settle();
    `CHK("half", 2'h0, {seg_out[15], seg_out[7]})
    keys.press(2);
    settle();
    `CHK("half", 2'h3, {seg_out[15], seg_out[7]})
    keys.view(panel_monitor_pkg::ITEM_STATUS);
    settle();
    `CHK("status", 32'h065B4F66, seg_out[31:0])
    // an item without its own format shows the generic value
    @(posedge clk_sys);
    generic_value <= 16'h0007;
    keys.view(panel_monitor_pkg::ITEM_TEMP);
    settle();
    `CHK("generic", 40'h3F3F3F3F07, seg_out)
  endtask
  // verdict and end of run
  task automatic complete_run;
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reg();
    t_enc();
    t_io();
    t_analog();
    t_dev();
    t_cause();
    t_views();
    complete_run();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
